/* File: dv/hw_break_unit_bench.sv */
// self-checking bench of the hardware break condition unit
`timescale 1ns/1ps
`default_nettype none
module hw_break_unit_bench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rst;
    logic awready, wready, bvalid, arready, rvalid, halt_req, irq, bus_cycle;
    logic [31:0] awaddr, wdata, araddr, rdata, fetch_addr, v;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] ev_req, event_hit;
    logic [7:0]  exc_req, exc_event;
    int          miscompares, num_checks, cyc;
    // design and target bus model
    hw_break_unit hw_break_unit_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_cycle(bus_cycle),
        .event_hit(event_hit), .exc_event(exc_event), .fetch_addr(fetch_addr),
        .prog_restart(rst), .halt_req(halt_req), .irq(irq));
    target_bus_model target_bus_model_inst (.aclk(aclk), .ev_req(ev_req),
        .exc_req(exc_req), .bus_cycle(bus_cycle), .event_hit(event_hit),
        .exc_event(exc_event), .fetch_addr(fetch_addr));
    // clock and hang guard
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            miscompares++;
            stop_test;
        end
    end
    task automatic stop_test;
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] ad(input logic [4:0] i);
        return {25'h0, i, 2'b00};
    endfunction
    // write: both halves offered together, each dropped when taken
    task automatic wr(input logic [4:0] i, input logic [31:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awaddr <= ad(i);
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin aw = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready === 1'b1) begin w = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask
    task automatic rd(input logic [4:0] i);
        @(posedge aclk);
        araddr <= ad(i);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        v = rdata;
        r = rresp;
    endtask
    // optional restart, one detect cycle, then cycles until halt
    task automatic lat(input logic [15:0] e, input logic [7:0] x, input logic rs,
                       input int ex);
        int n;
        n = 99;
        @(posedge aclk);
        rst <= rs;
        @(posedge aclk);
        rst <= 1'b0;
        ev_req <= e;
        exc_req <= x;
        @(posedge aclk);
        ev_req <= 16'h0;
        exc_req <= 8'h0;
        for (int i = 0; i < 30; i++)
        begin
            @(posedge aclk);
            if (halt_req === 1'b1) begin n = i; break; end
        end
        chk("halt latency", n, ex);
    endtask
    task automatic t_reset;
        rd(hbreak_pkg::IDX_CTRL);
        chk("ctrl reset", v, 32'h0000_0001);
        rd(hbreak_pkg::IDX_DELAY);
        chk("delay reset", v, 32'h0000_0000);
        rd(5'h19);
        chk("unmapped resp", r, hbreak_pkg::RESP_SLVERR);
        wr(hbreak_pkg::IDX_STATUS, 32'h0);
        chk("ro write resp", r, hbreak_pkg::RESP_SLVERR);
    endtask
    // staged mask, irq raise, mask and clear, then delay count
    task automatic t_or;
        wr(hbreak_pkg::IDX_IRQ_EN, 32'h0000_0002);
        wr(hbreak_pkg::IDX_OR_MASK, 32'h0000_8004);
        lat(16'h0004, 8'h00, 1'b1, 99);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0004, 8'h00, 1'b1, 1);
        @(posedge aclk);
        chk("irq raised", irq, 1'b1);
        rd(hbreak_pkg::IDX_IRQ_STAT);
        chk("irq status", v, 32'h0000_0003);
        lat(16'h8000, 8'h00, 1'b1, 1);
        lat(16'h0001, 8'h00, 1'b1, 99);
        wr(hbreak_pkg::IDX_IRQ_EN, 32'h0000_0000);
        chk("irq masked", irq, 1'b0);
        wr(hbreak_pkg::IDX_IRQ_CLR, 32'h0000_0003);
        rd(hbreak_pkg::IDX_IRQ_STAT);
        chk("irq cleared", v, 32'h0000_0000);
        wr(hbreak_pkg::IDX_DELAY, 32'h0000_0003);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0004, 8'h00, 1'b1, 4);
        wr(hbreak_pkg::IDX_DELAY, 32'h0000_0000);
    endtask
    // accumulated history, commit clearing it, simultaneous
    task automatic t_and;
        wr(hbreak_pkg::IDX_CTRL, 32'h0000_0002);
        wr(hbreak_pkg::IDX_AND_MASK, 32'h0000_0003);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0002, 8'h00, 1'b1, 99);
        lat(16'h0001, 8'h00, 1'b0, 1);
        lat(16'h0001, 8'h00, 1'b1, 99);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0002, 8'h00, 1'b0, 99);
        wr(hbreak_pkg::IDX_CTRL, 32'h0000_0006);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0001, 8'h00, 1'b1, 99);
        lat(16'h0002, 8'h00, 1'b0, 99);
        lat(16'h0003, 8'h00, 1'b0, 1);
    endtask
    // two ordered steps, reset event 5 in between
    task automatic t_seq;
        wr(hbreak_pkg::IDX_CTRL, 32'h0000_000e);
        wr(hbreak_pkg::IDX_SEQ_EV, 32'h0000_0021);
        wr(hbreak_pkg::IDX_SEQ_CTL, 32'h0000_00a5);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0004, 8'h00, 1'b1, 99);
        lat(16'h0002, 8'h00, 1'b1, 99);
        lat(16'h0020, 8'h00, 1'b0, 99);
        lat(16'h0004, 8'h00, 1'b0, 99);
        lat(16'h0002, 8'h00, 1'b1, 99);
        lat(16'h0004, 8'h00, 1'b0, 1);
    endtask
    // subroutine range, then two-path state walk
    task automatic t_alt;
        wr(hbreak_pkg::IDX_CTRL, 32'h0000_000a);
        wr(hbreak_pkg::IDX_SUB_EV, 32'h0000_0003);
        wr(hbreak_pkg::IDX_RANGE_HI, 32'h0000_1000);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0008, 8'h00, 1'b1, 1);
        wr(hbreak_pkg::IDX_RANGE_HI, 32'h0000_0fff);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0008, 8'h00, 1'b1, 99);
        wr(hbreak_pkg::IDX_CTRL, 32'h0000_0012);
        wr(hbreak_pkg::IDX_PATH0, 32'h0000_0141);
        wr(hbreak_pkg::IDX_PATH0 + 5'h01, 32'h0000_0192);
        wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
        lat(16'h0004, 8'h00, 1'b1, 99);
        lat(16'h0002, 8'h00, 1'b0, 99);
        lat(16'h0004, 8'h00, 1'b0, 1);
    endtask
    // each exceptional event alone, the other seven must not break
    task automatic t_exc;
        wr(hbreak_pkg::IDX_CTRL, 32'h0000_0000);
        for (int k = 0; k < 8; k++)
        begin
            wr(hbreak_pkg::IDX_EXC_EN, 32'h1 << k);
            wr(hbreak_pkg::IDX_COMMIT, 32'h0000_0001);
            lat(16'h0000, 8'h01 << k, 1'b1, 1);
            lat(16'h0000, ~(8'h01 << k), 1'b1, 99);
        end
    endtask
    // reset, then scenarios
    initial
    begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rst} = 8'h00;
        {awaddr, wdata, araddr, ev_req, exc_req} = 120'h0;
        {miscompares, num_checks, cyc} = 96'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_or;
        t_and;
        t_seq;
        t_alt;
        t_exc;
        stop_test;
    end
endmodule // hw_break_unit_bench
`default_nettype wire

/* File: dv/target_bus_model.sv */
// model of the monitored target bus cycles and event detectors
`timescale 1ns/1ps
`default_nettype none
module target_bus_model (
    // clock
    input  wire logic        aclk,
    // bench requests
    input  wire logic [15:0] ev_req,
    input  wire logic [7:0]  exc_req,
    // monitored bus
    output logic             bus_cycle,
    output logic [15:0]      event_hit,
    output logic [7:0]       exc_event,
    output logic [31:0]      fetch_addr
);
    // every clock is a bus cycle, detects last one cycle and idle low
    always_ff @(posedge aclk)
    begin
        bus_cycle <= 1'b1;
        event_hit <= ev_req;
        exc_event <= exc_req;
    end
    // fixed fetch address, range mode is tested by moving the upper range bound
    assign fetch_addr = 32'h0000_1000;
endmodule // target_bus_model
`default_nettype wire

/* File: hw/break_delay.sv */
// delay counter between a detected breakpoint and the halt
`timescale 1ns/1ps
`default_nettype none
module break_delay (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // control
    input  wire logic        start,
    input  wire logic [15:0] delay,
    input  wire logic        tick,
    input  wire logic        clear,
    // state
    output logic             halt,
    output logic             busy
);
    logic [15:0] cnt_r;

    // count bus cycles, zero halts at the next edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= 16'h0000;
            busy  <= 1'b0;
            halt  <= 1'b0;
        end
        else if (ce)
        begin
            if (clear)
            begin
                busy <= 1'b0;
                halt <= 1'b0;
            end
            else if (start && !busy && !halt)
            begin
                cnt_r <= delay;
                busy  <= (delay != 16'h0000);  // RQ2
                halt  <= (delay == 16'h0000);  // RQ3
            end
            else if (busy && tick)
            begin
                cnt_r <= cnt_r - 16'h0001;
                if (cnt_r == 16'h0001)
                begin
                    busy <= 1'b0;
                    halt <= 1'b1;              // RQ2
                end
            end
        end
    end
endmodule // break_delay
`default_nettype wire

/* File: hw/hbreak_pkg.sv */
// constants, field layout and types of the hardware break condition unit
package hbreak_pkg;
    // event counts
    localparam int NUM_EVENTS = 16;
    localparam int NUM_EXC    = 8;
    localparam int NUM_PATHS  = 9;
    localparam int SEQ_STEPS  = 6;
    localparam int CFG_WORDS  = 20;
    localparam int IDX_W      = 5;
    // register word indices, byte address is four times the index
    localparam logic [4:0] IDX_CTRL     = 5'h00;
    localparam logic [4:0] IDX_OR_MASK  = 5'h01;
    localparam logic [4:0] IDX_AND_MASK = 5'h02;
    localparam logic [4:0] IDX_SUB_EV   = 5'h03;
    localparam logic [4:0] IDX_RANGE_LO = 5'h04;
    localparam logic [4:0] IDX_RANGE_HI = 5'h05;
    localparam logic [4:0] IDX_SEQ_EV   = 5'h06;
    localparam logic [4:0] IDX_SEQ_CTL  = 5'h07;
    localparam logic [4:0] IDX_ST_CTL   = 5'h08;
    localparam logic [4:0] IDX_EXC_EN   = 5'h09;
    localparam logic [4:0] IDX_DELAY    = 5'h0a;
    localparam logic [4:0] IDX_PATH0    = 5'h0b;
    localparam logic [4:0] IDX_COMMIT   = 5'h14;
    localparam logic [4:0] IDX_STATUS   = 5'h15;
    localparam logic [4:0] IDX_IRQ_STAT = 5'h16;
    localparam logic [4:0] IDX_IRQ_EN   = 5'h17;
    localparam logic [4:0] IDX_IRQ_CLR  = 5'h18;
    // control word fields
    localparam int CTRL_OR_EN    = 0;
    localparam int CTRL_ALT_EN   = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // sequence and state control fields
    localparam int SEQ_RST_LSB = 0;
    localparam int SEQ_LEN_LSB = 4;
    localparam int ST_RST_LSB  = 0;
    localparam int ST_RST_EN   = 4;
    localparam int SEQ_RST_EN  = 7;
    // transition path fields
    localparam int PATH_EV_LSB   = 0;
    localparam int PATH_FROM_LSB = 4;
    localparam int PATH_TO_LSB   = 6;
    localparam int PATH_EN       = 8;
    // status and interrupt bits
    localparam int STAT_HALT     = 0;
    localparam int STAT_DELAY    = 1;
    localparam int STAT_STEP_LSB = 4;
    localparam int STAT_ST_LSB   = 8;
    localparam int IRQ_HIT       = 0;
    localparam int IRQ_HALT      = 1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // alternative combinations
    typedef enum logic [2:0] {
        MODE_ACC = 3'b000,
        MODE_SIM = 3'b001,
        MODE_SUB = 3'b010,
        MODE_SEQ = 3'b011,
        MODE_ST  = 3'b100
    } alt_mode_t;
    // transition machine states, reaching the last one breaks
    typedef enum logic [1:0] {
        ST_START = 2'b00,
        ST_MID   = 2'b01,
        ST_BREAK = 2'b10
    } st_state_t;
endpackage

/* File: hw/hw_break_unit.sv */
// hardware break condition unit with axi4-lite register slave
// Contract
// [RQ1] sixteen event inputs serve as break conditions
// [RQ2] halt follows break after configured cycle count
// [RQ3] delay 0 to 65535 cycles, default zero
// [RQ4] or mode breaks on any enabled event
// [RQ5] accumulated and breaks once all seen
// [RQ6] simultaneous and needs all events together
// [RQ7] subroutine breaks on event inside address range
// [RQ8] six ordered steps, reset event restarts
// [RQ9] three states, nine paths, reset point
// [RQ10] or, alternative, exception enable independently
// [RQ11] or combination enabled after reset
// [RQ12] one of five alternative modes selected
// [RQ13] alternative combination disabled after reset
// [RQ14] software keeps state round trips ten microseconds
// [RQ15] each exceptional event has own enable
// [RQ16] staged settings act only after commit
// [RQ17] commit or restart clears progress history
`timescale 1ns/1ps
`default_nettype none
module hw_break_unit (
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite write channels
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read channels
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // monitored target bus
    input  wire logic        bus_cycle,
    input  wire logic [15:0] event_hit,
    input  wire logic [7:0]  exc_event,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        prog_restart,
    // results
    output logic             halt_req,
    output logic             irq
);
    logic [31:0] stg_r [0:hbreak_pkg::CFG_WORDS-1];
    logic [31:0] act_r [0:hbreak_pkg::CFG_WORDS-1];
    logic [31:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        aw_have_r;
    logic        w_have_r;
    logic [1:0]  irq_stat_r;
    logic [1:0]  irq_en_r;
    logic [15:0] acc_seen_r;
    logic [2:0]  step_r;
    hbreak_pkg::st_state_t st_r;
    logic        wr_go;
    logic [4:0]  wr_idx;
    logic [4:0]  rd_idx;
    logic        commit;
    logic        cyc;
    logic        clr_hist;
    logic        delay_busy;
    logic        armed;
    logic [15:0] ev;
    hbreak_pkg::alt_mode_t mode;
    logic        or_hit;
    logic        alt_hit;
    logic        exc_hit;
    logic        break_hit;
    logic [15:0] and_mask;
    logic [15:0] acc_now;
    logic [2:0]  seq_len;
    logic [3:0]  seq_ev;
    logic        seq_rst;
    logic        seq_adv;
    logic        st_rst;
    logic        st_fire;
    hbreak_pkg::st_state_t st_nxt;
    logic [8:0]  path_fire;
    logic [31:0] rd_val;
    logic [31:0] status;
    logic [1:0]  irq_clr;

    // bus write decode, both halves must be held before the write commits
    assign cyc           = ce & bus_cycle;
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
    assign wr_go  = ce && aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_idx = aw_addr_r[6:2];
    assign commit = wr_go && (wr_idx == hbreak_pkg::IDX_COMMIT) && w_data_r[0];
    assign irq_clr = (wr_go && wr_idx == hbreak_pkg::IDX_IRQ_CLR) ? w_data_r[1:0] : 2'h0;
    assign clr_hist = (ce && prog_restart) || commit;

    // write address and data capture, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            aw_addr_r    <= 32'h0000_0000;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= hbreak_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_idx < hbreak_pkg::IDX_STATUS ||
                                 wr_idx > hbreak_pkg::IDX_IRQ_STAT) &&
                                wr_idx <= hbreak_pkg::IDX_IRQ_CLR ?
                                hbreak_pkg::RESP_OKAY : hbreak_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // staged and active copies, one per configuration word
    genvar gi;
    generate
        for (gi = 0; gi < hbreak_pkg::CFG_WORDS; gi++)
        begin : g_cfg
            localparam logic [31:0] RV = (gi == 0) ? hbreak_pkg::CTRL_RESET : 32'h0;
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    stg_r[gi] <= RV;                   // RQ11 RQ13
                    act_r[gi] <= RV;
                end
                else if (ce)
                begin
                    if (wr_go && wr_idx == 5'(gi))
                    begin
                        for (int b = 0; b < 4; b++)
                            if (w_strb_r[b])
                                stg_r[gi][b*8 +: 8] <= w_data_r[b*8 +: 8];
                    end
                    if (commit)
                        act_r[gi] <= stg_r[gi];        // RQ16
                end
            end
        end
    endgenerate

    // read channel, one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = s_axi_araddr[6:2];
    assign status = {22'h0, st_r, 1'b0, step_r, 2'h0, delay_busy, halt_req};
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (rd_idx < 5'(hbreak_pkg::CFG_WORDS))
            rd_val = stg_r[rd_idx];
        else if (rd_idx == hbreak_pkg::IDX_STATUS)
            rd_val = status;
        else if (rd_idx == hbreak_pkg::IDX_IRQ_STAT)
            rd_val = {30'h0, irq_stat_r};
        else if (rd_idx == hbreak_pkg::IDX_IRQ_EN)
            rd_val = {30'h0, irq_en_r};
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= hbreak_pkg::RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= (rd_idx < 5'(hbreak_pkg::CFG_WORDS) ||
                                 (rd_idx >= hbreak_pkg::IDX_STATUS &&
                                  rd_idx <= hbreak_pkg::IDX_IRQ_EN)) ?
                                hbreak_pkg::RESP_OKAY : hbreak_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // detection only while armed, so one hit starts one delay
    assign armed = cyc && !delay_busy && !halt_req;
    assign ev    = event_hit;                                           // RQ1
    assign mode  = hbreak_pkg::alt_mode_t'(act_r[hbreak_pkg::IDX_CTRL][hbreak_pkg::CTRL_MODE_LSB +: 3]);
    assign and_mask = act_r[hbreak_pkg::IDX_AND_MASK][15:0];
    assign acc_now  = acc_seen_r | (ev & and_mask);
    assign or_hit = act_r[hbreak_pkg::IDX_CTRL][hbreak_pkg::CTRL_OR_EN] &&
                    |(ev & act_r[hbreak_pkg::IDX_OR_MASK][15:0]);        // RQ4
    assign exc_hit = |(exc_event & act_r[hbreak_pkg::IDX_EXC_EN][7:0]);  // RQ15

    // sequence step selection, lengths above six clamp to six
    assign seq_len = (act_r[hbreak_pkg::IDX_SEQ_CTL][hbreak_pkg::SEQ_LEN_LSB +: 3] >
                      3'(hbreak_pkg::SEQ_STEPS)) ? 3'(hbreak_pkg::SEQ_STEPS) :
                     act_r[hbreak_pkg::IDX_SEQ_CTL][hbreak_pkg::SEQ_LEN_LSB +: 3];
    assign seq_ev  = act_r[hbreak_pkg::IDX_SEQ_EV][{step_r, 2'b00} +: 4];
    assign seq_rst = act_r[hbreak_pkg::IDX_SEQ_CTL][hbreak_pkg::SEQ_RST_EN] &&
                     ev[act_r[hbreak_pkg::IDX_SEQ_CTL][hbreak_pkg::SEQ_RST_LSB +: 4]];
    assign seq_adv = !seq_rst && seq_len != 3'h0 && ev[seq_ev];
    assign st_rst  = act_r[hbreak_pkg::IDX_ST_CTL][hbreak_pkg::ST_RST_EN] &&
                     ev[act_r[hbreak_pkg::IDX_ST_CTL][hbreak_pkg::ST_RST_LSB +: 4]];

    // transition paths, lowest numbered firing path wins
    generate
        for (gi = 0; gi < hbreak_pkg::NUM_PATHS; gi++)
        begin : g_path
            localparam int W = int'(hbreak_pkg::IDX_PATH0) + gi;
            assign path_fire[gi] = act_r[W][hbreak_pkg::PATH_EN] &&
                act_r[W][hbreak_pkg::PATH_FROM_LSB +: 2] == st_r &&
                act_r[W][hbreak_pkg::PATH_TO_LSB +: 2] != 2'h3 &&
                ev[act_r[W][hbreak_pkg::PATH_EV_LSB +: 4]];          // RQ9
        end
    endgenerate
    always_comb
    begin
        st_nxt  = st_r;
        st_fire = 1'b0;
        for (int p = hbreak_pkg::NUM_PATHS - 1; p >= 0; p--)
            if (path_fire[p])
            begin
                st_fire = 1'b1;
                st_nxt  = hbreak_pkg::st_state_t'(
                    act_r[int'(hbreak_pkg::IDX_PATH0) + p][hbreak_pkg::PATH_TO_LSB +: 2]);
            end
    end

    // alternative combination, illegal mode codes never break
    always_comb
    begin
        alt_hit = 1'b0;
        unique case (mode)
            hbreak_pkg::MODE_ACC: alt_hit = and_mask != 16'h0 && acc_now == and_mask; // RQ5
            hbreak_pkg::MODE_SIM: alt_hit = and_mask != 16'h0 &&
                                            (ev & and_mask) == and_mask;              // RQ6
            hbreak_pkg::MODE_SUB: alt_hit =
                ev[act_r[hbreak_pkg::IDX_SUB_EV][3:0]] &&
                fetch_addr >= act_r[hbreak_pkg::IDX_RANGE_LO] &&
                fetch_addr <= act_r[hbreak_pkg::IDX_RANGE_HI];                        // RQ7
            hbreak_pkg::MODE_SEQ: alt_hit = seq_adv && (step_r + 3'h1) == seq_len;    // RQ8
            hbreak_pkg::MODE_ST:  alt_hit = !st_rst && st_fire &&
                                            st_nxt == hbreak_pkg::ST_BREAK;           // RQ9
            default:              alt_hit = 1'b0;                                     // RQ12
        endcase
    end
    assign break_hit = armed && (or_hit || exc_hit ||
                       (act_r[hbreak_pkg::IDX_CTRL][hbreak_pkg::CTRL_ALT_EN] && alt_hit)); // RQ10

    // progress history, wiped by commit or restart
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_seen_r <= 16'h0000;
            step_r     <= 3'h0;
            st_r       <= hbreak_pkg::ST_START;
        end
        else if (ce)
        begin
            if (clr_hist)
            begin
                acc_seen_r <= 16'h0000;                    // RQ17
                step_r     <= 3'h0;
                st_r       <= hbreak_pkg::ST_START;
            end
            else if (armed)
            begin
                acc_seen_r <= alt_hit ? 16'h0000 : acc_now; // RQ5
                if (mode == hbreak_pkg::MODE_SEQ)
                    step_r <= (seq_rst || alt_hit) ? 3'h0 : step_r + 3'(seq_adv); // RQ8
                if (mode == hbreak_pkg::MODE_ST)
                    st_r <= (st_rst || alt_hit) ? hbreak_pkg::ST_START : st_nxt;  // RQ9
            end
        end
    end

    // halt delay counter
    break_delay break_delay_inst (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .start   (break_hit),
        .delay   (act_r[hbreak_pkg::IDX_DELAY][15:0]),
        .tick    (bus_cycle),
        .clear   (prog_restart),
        .halt    (halt_req),
        .busy    (delay_busy)
    );

    // sticky interrupt status, a new event beats a clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_r <= 2'h0;
            irq_en_r   <= 2'h0;
        end
        else if (ce)
        begin
            irq_stat_r[hbreak_pkg::IRQ_HIT]  <= break_hit ||
                (irq_stat_r[hbreak_pkg::IRQ_HIT] && !irq_clr[hbreak_pkg::IRQ_HIT]);
            irq_stat_r[hbreak_pkg::IRQ_HALT] <= halt_req ||
                (irq_stat_r[hbreak_pkg::IRQ_HALT] && !irq_clr[hbreak_pkg::IRQ_HALT]);
            if (wr_go && wr_idx == hbreak_pkg::IDX_IRQ_EN && w_strb_r[0])
                irq_en_r <= w_data_r[1:0];
        end
    end
    assign irq = |(irq_stat_r & irq_en_r);

    // checks
    sequence s_hit_delayed;
        break_hit && act_r[hbreak_pkg::IDX_DELAY][15:0] != 16'h0 && !prog_restart;
    endsequence
    or_any_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
        armed && or_hit |-> break_hit) else $error("or event did not break");
    delay_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ3
        break_hit && act_r[hbreak_pkg::IDX_DELAY][15:0] == 16'h0 && !prog_restart |=> halt_req)
        else $error("zero delay did not halt at once");
    delay_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
        s_hit_delayed |=> !halt_req && delay_busy) else $error("halt came before delay");
    sim_and_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
        mode == hbreak_pkg::MODE_SIM && (ev & and_mask) != and_mask |-> !alt_hit)
        else $error("simultaneous and broke with missing event");
    sub_range_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
        mode == hbreak_pkg::MODE_SUB && fetch_addr > act_r[hbreak_pkg::IDX_RANGE_HI]
        |-> !alt_hit) else $error("subroutine broke outside range");
    exc_sel_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ15
        armed && exc_hit |-> break_hit) else $error("enabled exception did not break");
    stage_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ16
        !commit |=> act_r[hbreak_pkg::IDX_CTRL] == $past(act_r[hbreak_pkg::IDX_CTRL]))
        else $error("active settings changed without commit");
    hist_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ17
        clr_hist |=> acc_seen_r == 16'h0 && step_r == 3'h0 && st_r == hbreak_pkg::ST_START)
        else $error("history not cleared");
    seq_reset_a: assert property (@(posedge aclk) disable iff (!aresetn) // RQ8
        armed && mode == hbreak_pkg::MODE_SEQ && seq_rst |=> step_r == 3'h0)
        else $error("sequence reset point ignored");
    reset_dflt_a: assert property (@(posedge aclk) // RQ11 RQ13
        !aresetn |=> act_r[hbreak_pkg::IDX_CTRL] == hbreak_pkg::CTRL_RESET)
        else $error("wrong default enables");
endmodule // hw_break_unit
`default_nettype wire
